// >>> rtl/single_cycle_core_timing.sv
// Purpose: per-instruction cycle timing, address strobe, external data bus
// Assumes: opcode, request and wait count come from logic on sys_clk
// Notes:   machine cycle is two sys_clk phases so the strobe can sit high
//          for exactly its first half from a flip-flop
`timescale 1ns/10ps
`default_nettype none

module single_cycle_core_timing #(
  parameter int WAIT_W = 3
) (
  input  wire logic                               sys_clk,
  input  wire logic                               reset_n,
  input  wire logic                               instr_valid,
  input  wire logic [core_timing_pkg::OPC_W-1:0]  opcode,
  input  wire core_timing_pkg::xdata_req_t        xdata_req,
  input  wire logic [WAIT_W-1:0]                  external_wait_state_count,
  input  wire logic                               baud_tick_in,
  input  wire logic [7:0]                         port0_in,
  output logic                                    instr_accept,
  output logic                                    instr_done,
  output logic                                    instr_busy,
  output logic [core_timing_pkg::BYTES_W-1:0]     instr_bytes,
  output logic [7:0]                              xdata_rdata,
  output logic                                    xdata_rvalid,
  output logic                                    timer_tick,
  output logic                                    ale,
  output logic [7:0]                              port0_out,
  output logic                                    port0_oe,
  output logic [7:0]                              port2_out,
  output logic                                    rd_n,
  output logic                                    wr_n,
  output logic                                    prog_store_en_n,
  output logic                                    baud_tick_out
);

  if (WAIT_W < 1 || WAIT_W > core_timing_pkg::WAIT_MAX_W) begin : g_chk
    $error("WAIT_W out of range");
  end

  function automatic core_timing_pkg::op_timing_t mk(
    input logic [core_timing_pkg::BYTES_W-1:0] b,
    input logic [core_timing_pkg::CYC_W-1:0]   c
  );
    core_timing_pkg::op_timing_t t;
    t = '0;
    t.bytes = b;
    t.cycles = c;
    return t;
  endfunction

  function automatic core_timing_pkg::op_timing_t op_decode(
    input logic [core_timing_pkg::OPC_W-1:0] op
  );
    core_timing_pkg::op_timing_t t;
    t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
    casez (op)
      // alu groups: add, addc, orl, anl, xrl, subb
      8'h2?, 8'h3?, 8'h4?, 8'h5?, 8'h6?, 8'h9?: begin
        unique casez (op[3:0])
          4'h4, 4'h5: t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2); // [RQ9]
          4'h6, 4'h7: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_2); // [RQ8]
          4'b1???:    t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1); // [RQ7]
          default:    t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
        endcase
      end
      default: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
    endcase
    casez (op)
      8'h42, 8'h52, 8'h62: t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'h43, 8'h53, 8'h63: t = mk(core_timing_pkg::BYTES_3, core_timing_pkg::CYC_3); // [RQ10]
      8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hE4, 8'hF4:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1); // [RQ16]
      8'h04, 8'h14, 8'b000?_1???:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
      8'h05, 8'h15: t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'h06, 8'h07, 8'h16, 8'h17:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_2);
      8'hA3: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_3); // [RQ11]
      8'hA4, 8'h84: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_MULDIV); // [RQ20]
      8'hD4: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_2);
      8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF,
      8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
      8'hE6, 8'hE7, 8'hF6, 8'hF7:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_2);
      8'hE5, 8'hF5, 8'h74, 8'b0111_1???, 8'h76, 8'h77:
        t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'b1010_1???, 8'b1000_1???, 8'h86, 8'h87, 8'hA6, 8'hA7:
        t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'h85, 8'h75: t = mk(core_timing_pkg::BYTES_3, core_timing_pkg::CYC_3); // [RQ14]
      8'h90: t = mk(core_timing_pkg::BYTES_3, core_timing_pkg::CYC_3); // [RQ15]
      8'h93, 8'h83: begin
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_4); // [RQ12]
        t.code_read = 1'b1;
      end
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_XDATA); // [RQ13]
        t.xdata = 1'b1;
        t.xwrite = op[4];
        t.xwide = ~op[1];
      end
      8'hC0, 8'hD0: t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2); // [RQ17]
      8'b1100_1???: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
      8'hC6, 8'hC7, 8'hD6, 8'hD7:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_2); // [RQ18]
      8'hC5: t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'hC3, 8'hD3, 8'hB3, 8'h00:
        t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_1);
      8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
        t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_2);
      8'h73: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_3);
      8'h22, 8'h32: t = mk(core_timing_pkg::BYTES_1, core_timing_pkg::CYC_4);
      8'b???0_0001, 8'b???1_0001, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
        t = mk(core_timing_pkg::BYTES_2, core_timing_pkg::CYC_3);
      8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'hB4, 8'hB5, 8'hD5,
      8'hB6, 8'hB7, 8'b1011_1???:
        t = mk(core_timing_pkg::BYTES_3, core_timing_pkg::CYC_4);
      default: ;
    endcase
    return t;
  endfunction

  core_timing_pkg::op_timing_t dec;
  core_timing_pkg::op_timing_t cur_reg;
  core_timing_pkg::xdata_req_t xreq_reg;
  core_timing_pkg::run_state_t state_reg;
  logic [core_timing_pkg::CNT_W-1:0] total;
  logic [core_timing_pkg::CNT_W-1:0] left_reg;
  logic [core_timing_pkg::CNT_W-1:0] idx_reg;
  logic [core_timing_pkg::CNT_W-1:0] idx_next;
  logic                              phase_reg;
  logic                              mc_end;
  logic                              last_mc;
  logic                              take;
  logic                              run_step;
  logic                              xbus_step;
  logic                              strobe_on;
  logic                              strobe_off;
  logic                              bus_end;
  logic                              read_cap;
  logic [7:0]                        p0_s1_reg;
  logic [7:0]                        p0_s2_reg;
  logic [7:0]                        p0_s3_reg;
  logic [7:0]                        p0_stable_reg;
  logic                              baud_half_reg;

  // wait states only ever lengthen external data moves
  assign dec      = op_decode(opcode);
  assign total    = {{(core_timing_pkg::CNT_W-core_timing_pkg::CYC_W){1'b0}}, dec.cycles}
                  + (dec.xdata ? core_timing_pkg::CNT_W'(external_wait_state_count)
                               : '0); // [RQ5] [RQ21] [RQ22]
  assign mc_end   = phase_reg;
  assign last_mc  = (state_reg == core_timing_pkg::ST_RUN) && (left_reg == '0);
  assign take     = instr_valid && mc_end
                  && ((state_reg == core_timing_pkg::ST_IDLE) || (left_reg == '0));
  assign idx_next = idx_reg + core_timing_pkg::CNT_W'(1);
  assign run_step   = mc_end && (state_reg == core_timing_pkg::ST_RUN) && (left_reg != '0);
  assign xbus_step  = run_step && cur_reg.xdata;
  assign strobe_on  = xbus_step && (idx_next == core_timing_pkg::XBUS_STROBE_IDX);
  assign strobe_off = xbus_step && (left_reg == core_timing_pkg::CNT_W'(1));
  assign bus_end    = take || (mc_end && last_mc);
  assign read_cap   = !mc_end && last_mc && cur_reg.xdata && !cur_reg.xwrite;

  // two phases per machine cycle; phase 1 closes the cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  // one timer advance per machine cycle, not per twelve
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= mc_end; // [RQ1]
    end
  end

  // instruction sequencing; back-to-back issue keeps one per cycle peak
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= core_timing_pkg::ST_IDLE;
    end else if (take) begin
      state_reg <= core_timing_pkg::ST_RUN;
    end else if (mc_end && last_mc) begin
      state_reg <= core_timing_pkg::ST_IDLE;
    end
  end

  // machine cycles still to run after the current one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      left_reg <= '0;
    end else if (take) begin
      left_reg <= total - core_timing_pkg::CNT_W'(1); // [RQ19]
    end else if (run_step) begin
      left_reg <= left_reg - core_timing_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_reg <= '0;
    end else if (take) begin
      idx_reg <= '0;
    end else if (run_step) begin
      idx_reg <= idx_next;
    end
  end

  // opcode timing and bus request held for the whole instruction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg  <= '0;
      xreq_reg <= '0;
    end else if (take) begin
      cur_reg  <= dec;
      xreq_reg <= xdata_req;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_accept <= 1'b0;
      instr_done   <= 1'b0;
      instr_busy   <= 1'b0;
    end else begin
      instr_accept <= take;
      instr_done   <= mc_end && last_mc;
      instr_busy   <= take || ((state_reg == core_timing_pkg::ST_RUN) && !(mc_end && last_mc));
    end
  end

  // byte length stays until the next accept
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_bytes <= '0;
    end else if (take) begin
      instr_bytes <= dec.bytes;
    end
  end

  // strobe high only in the first phase of an instruction's first cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ale <= 1'b0;
    end else begin
      ale <= take; // [RQ2] [RQ3]
    end
  end

  // program store enable never asserts: code comes from on-chip memory only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_store_en_n <= 1'b1;
    end else begin
      prog_store_en_n <= 1'b1; // [RQ4]
    end
  end

  // pin data: three stages, accepted once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_s1_reg     <= '0;
      p0_s2_reg     <= '0;
      p0_s3_reg     <= '0;
      p0_stable_reg <= '0;
    end else begin
      p0_s1_reg <= port0_in;
      p0_s2_reg <= p0_s1_reg;
      p0_s3_reg <= p0_s2_reg;
      if (p0_s2_reg == p0_s3_reg) begin
        p0_stable_reg <= p0_s3_reg;
      end
    end
  end

  // external data bus: address in cycle 0, strobe cycles 1..total-2,
  // release in the last cycle; slow ram needs the extra strobe cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port0_out <= core_timing_pkg::P0_RESET;
      port0_oe  <= 1'b0;
      port2_out <= core_timing_pkg::P2_RESET;
    end else if (take && dec.xdata) begin
      port0_out <= xdata_req.addr[7:0];
      port0_oe  <= 1'b1;
      if (dec.xwide) begin
        port2_out <= xdata_req.addr[15:8];
      end
    end else if (bus_end) begin
      port0_oe <= 1'b0;
    end else if (strobe_on) begin
      port0_oe  <= cur_reg.xwrite;
      port0_out <= xreq_reg.wdata;
    end
  end

  // read and write strobes are never low together
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else if (strobe_on) begin
      rd_n <= cur_reg.xwrite; // [RQ13]
      wr_n <= ~cur_reg.xwrite;
    end else if (bus_end || strobe_off) begin
      rd_n <= 1'b1; // [RQ21]
      wr_n <= 1'b1;
    end
  end

  // capture one clock after release: the synchroniser lags the pin by
  // four edges, as long as the shortest strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xdata_rdata  <= '0;
      xdata_rvalid <= 1'b0;
    end else begin
      xdata_rvalid <= read_cap;
      if (read_cap) begin
        xdata_rdata <= p0_stable_reg;
      end
    end
  end

  // every second divider tick passes: the added halving stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_half_reg <= 1'b0;
      baud_tick_out <= 1'b0;
    end else begin
      baud_tick_out <= baud_tick_in && baud_half_reg; // [RQ6]
      if (baud_tick_in) begin
        baud_half_reg <= ~baud_half_reg;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/core_timing_pkg.sv
// Purpose: shared constants and types for the single-cycle core timing block
// Assumes: one 200 MHz clock, machine cycle made of two clock phases
// Notes:   no software-visible registers; the wait count arrives as a plain input
//
// Functional notes
// (RQ1) timers advance once per machine cycle
// (RQ2) single-cycle instruction: strobe high first half
// (RQ3) multi-cycle: strobe high only first half-cycle
// (RQ4) never fetch program from external memory
// (RQ5) external data moves stretched by wait count
// (RQ6) baud divider has extra divide-by-two
// (RQ7) accumulator with register ALU: 1 byte, 1 cycle
// (RQ8) indirect accumulator operand: 1 byte, 2 cycles
// (RQ9) immediate or direct arithmetic: 2 bytes, 2 cycles
// (RQ10) logic immediate into direct: 3 bytes, 3 cycles
// (RQ11) data pointer increment: 1 byte, 3 cycles
// (RQ12) code table reads: 1 byte, 4 cycles
// (RQ13) external data moves: 1 byte, 4 cycles
// (RQ14) direct to direct move: 3 bytes, 3 cycles
// (RQ15) data pointer immediate load: 3 bytes, 3 cycles
// (RQ16) accumulator-only operations: 1 byte, 1 cycle
// (RQ17) push and pop: 2 bytes, 2 cycles
// (RQ18) indirect exchanges: 1 byte, 2 cycles
// (RQ19) most instructions one or two cycles
// (RQ20) multiply and divide: 1 byte, 9 cycles
// (RQ21) n wait states give four plus n cycles
// (RQ22) every cycle count means machine cycles

package core_timing_pkg;

  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int MC_PERIOD_NS      = 10;
  localparam int SYS_PER_MC        = MC_PERIOD_NS / SYS_CLK_PERIOD_NS;

  localparam int OPC_W   = 8;
  localparam int BYTES_W = 2;
  localparam int CYC_W   = 4;
  localparam int CNT_W   = 9;
  localparam int WAIT_MAX_W = 8;

  localparam logic [BYTES_W-1:0] BYTES_1 = 2'h1;
  localparam logic [BYTES_W-1:0] BYTES_2 = 2'h2;
  localparam logic [BYTES_W-1:0] BYTES_3 = 2'h3;

  localparam logic [CYC_W-1:0] CYC_1      = 4'h1;
  localparam logic [CYC_W-1:0] CYC_2      = 4'h2;
  localparam logic [CYC_W-1:0] CYC_3      = 4'h3;
  localparam logic [CYC_W-1:0] CYC_4      = 4'h4;
  localparam logic [CYC_W-1:0] CYC_MULDIV = 4'h9;
  localparam logic [CYC_W-1:0] CYC_XDATA  = 4'h4;

  localparam logic [CNT_W-1:0] XBUS_STROBE_IDX = 9'h001;

  localparam logic [7:0] P0_RESET = 8'hFF;
  localparam logic [7:0] P2_RESET = 8'hFF;

  typedef struct packed {
    logic [BYTES_W-1:0] bytes;
    logic [CYC_W-1:0]   cycles;
    logic               xdata;
    logic               xwrite;
    logic               xwide;
    logic               code_read;
  } op_timing_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xdata_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } run_state_t;

endpackage

// >>> dv/core_timing_checker.sv
// Purpose: port timing relations of the core timing block
// Assumes: one clock domain, reset_n async active low
// Notes:   strobe length judged from the wait count seen at accept
`timescale 1ns/10ps
`default_nettype none

module core_timing_checker #(
  parameter int WAIT_W = 3
) (
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic [WAIT_W-1:0] external_wait_state_count,
  input wire logic              baud_tick_in,
  input wire logic              instr_accept,
  input wire logic              instr_done,
  input wire logic              instr_busy,
  input wire logic              timer_tick,
  input wire logic              ale,
  input wire logic              port0_oe,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic              prog_store_en_n,
  input wire logic              baud_tick_out
);
  logic [WAIT_W-1:0] wait_reg;
  logic [7:0]        low_cnt_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) wait_reg <= '0;
    else if (instr_accept) wait_reg <= external_wait_state_count;
  end

  // counts low cycles of either strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= (rd_n & wr_n) ? 8'h00 : low_cnt_reg + 8'h01;
  end

  property p_timer_rate;
    timer_tick |=> !timer_tick ##1 timer_tick;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer tick period wrong");
  property p_ale_with_accept;
    ale |-> instr_accept;
  endproperty
  a_ale_with_accept: assert property (p_ale_with_accept) else $error("strobe outside first cycle");
  property p_ale_half;
    ale |=> !ale;
  endproperty
  a_ale_half: assert property (p_ale_half) else $error("strobe longer than half cycle");
  property p_accept_gap;
    instr_accept |=> !instr_accept;
  endproperty
  a_accept_gap: assert property (p_accept_gap) else $error("accept faster than one cycle");
  property p_no_fetch;
    prog_store_en_n;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("program store enable asserted");
  property p_baud_half;
    baud_tick_out |-> $past(baud_tick_in);
  endproperty
  a_baud_half: assert property (p_baud_half) else $error("baud output without input tick");
  property p_strobe_len;
    $rose(rd_n & wr_n) |-> low_cnt_reg == 2 * (2 + wait_reg);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_read_releases;
    !rd_n |-> !port0_oe;
  endproperty
  a_read_releases: assert property (p_read_releases) else $error("port driven during read");
  property p_one_strobe;
    rd_n | wr_n;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
  property p_accept_busy;
    instr_accept |-> instr_busy;
  endproperty
  a_accept_busy: assert property (p_accept_busy) else $error("busy low at accept");
  property p_done_after_busy;
    instr_done |-> $past(instr_busy);
  endproperty
  a_done_after_busy: assert property (p_done_after_busy) else $error("done without busy");

  c_read: cover property ($fell(rd_n));
  c_write: cover property ($fell(wr_n));
  c_baud: cover property (baud_tick_out);
endmodule

bind single_cycle_core_timing core_timing_checker #(.WAIT_W(WAIT_W)) core_timing_checker_inst (
  .sys_clk(sys_clk), .reset_n(reset_n),
  .external_wait_state_count(external_wait_state_count), .baud_tick_in(baud_tick_in),
  .instr_accept(instr_accept), .timer_tick(timer_tick), .ale(ale), .port0_oe(port0_oe),
  .instr_done(instr_done), .instr_busy(instr_busy),
  .rd_n(rd_n), .wr_n(wr_n), .prog_store_en_n(prog_store_en_n),
  .baud_tick_out(baud_tick_out));
`default_nettype wire

// >>> dv/ext_data_ram.sv
// Purpose: external data RAM on the multiplexed address/data port
// Assumes: address latched while the strobe is high
// Notes:   slow mode answers only after three low read cycles
`timescale 1ns/10ps
`default_nettype none

module ext_data_ram (
  input  wire logic       sys_clk,
  input  wire logic       slow,
  input  wire logic       ale,
  input  wire logic [7:0] port0_out,
  input  wire logic       port0_oe,
  input  wire logic [7:0] port2_out,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic      [7:0] port0_pin
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_reg;
  logic [7:0]  last_reg = 8'h00;
  logic [2:0]  age_reg = 3'h0;

  always @(posedge sys_clk) begin
    if (ale) addr_reg <= {port2_out, port0_out};
    if (!wr_n) mem[addr_reg] <= port0_out;
    age_reg <= rd_n ? 3'h0 : (age_reg == 3'h7 ? 3'h7 : age_reg + 3'h1);
    last_reg <= port0_pin;
  end

  // released bus flips every cycle so stale data never reads as valid
  always_comb begin
    if (port0_oe) port0_pin = port0_out;
    else if (!rd_n && (!slow || age_reg >= 3'h3)) port0_pin = mem[addr_reg];
    else port0_pin = ~last_reg;
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self-checking bench for the core timing block
// Assumes: external RAM model on the multiplexed port
// Notes:   instruction length taken as gap between back-to-back accepts
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam logic [15:0] TBL [26] = '{16'h2811, 16'h2612, 16'h2422, 16'h9422, 16'h5333,
    16'h4333, 16'hA313, 16'h9314, 16'h8314, 16'h8533, 16'h9033, 16'h2311, 16'h3311,
    16'hC411, 16'hE411, 16'hF411, 16'hC022, 16'hD022, 16'hC612, 16'hD612, 16'hA419,
    16'h8419, 16'hE014, 16'hE214, 16'hF014, 16'hF214};
  logic                        sys_clk = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        instr_valid = 1'b0;
  logic [7:0]                  opcode = 8'h00;
  core_timing_pkg::xdata_req_t xdata_req = '0;
  logic [2:0]                  wait_cnt = 3'h0;
  logic                        baud_in = 1'b0;
  logic                        slow = 1'b0;
  logic [7:0]                  p0_pin, p0_out, p2_out, rdata, got;
  logic                        accept, rvalid, tick, ale, oe, rd_n, wr_n, pse_n, baud_out;
  logic [1:0]                  nbytes;
  int                          failures = 0;
  int                          checked = 0;

  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (rvalid) got = rdata;

  single_cycle_core_timing #(.WAIT_W(3)) single_cycle_core_timing_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid), .opcode(opcode),
    .xdata_req(xdata_req), .external_wait_state_count(wait_cnt), .baud_tick_in(baud_in),
    .port0_in(p0_pin), .instr_accept(accept), .instr_done(), .instr_busy(),
    .instr_bytes(nbytes), .xdata_rdata(rdata), .xdata_rvalid(rvalid), .timer_tick(tick),
    .ale(ale), .port0_out(p0_out), .port0_oe(oe), .port2_out(p2_out), .rd_n(rd_n),
    .wr_n(wr_n), .prog_store_en_n(pse_n), .baud_tick_out(baud_out));

  ext_data_ram ext_data_ram_inst (
    .sys_clk(sys_clk), .slow(slow), .ale(ale), .port0_out(p0_out), .port0_oe(oe),
    .port2_out(p2_out), .rd_n(rd_n), .wr_n(wr_n), .port0_pin(p0_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // offers one opcode twice back to back; gap is the first one's length
  task automatic run_op(input logic [7:0] op, input logic [15:0] addr,
                        input logic [2:0] n, output int gap, output int ales);
    int t0;
    @(posedge sys_clk);
    opcode <= op;
    xdata_req <= {addr, 8'hA5 ^ addr[7:0]};
    wait_cnt <= n;
    instr_valid <= 1'b1;
    t0 = -1;
    gap = -1;
    ales = 0;
    for (int k = 0; k < 100 && gap < 0; k++) begin
      @(negedge sys_clk);
      if (accept === 1'b1 && t0 >= 0) gap = k - t0;
      else begin
        if (accept === 1'b1) t0 = k;
        if (t0 >= 0) ales += ale;
      end
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
  endtask

  task automatic t_timer;
    int n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      n += tick;
    end
    check(n, 20);
    check(pse_n, 1);
  endtask

  task automatic t_table;
    int g, a;
    for (int i = 0; i < 26; i++) begin
      run_op(TBL[i][15:8], 16'h1200 + i, 3'h0, g, a);
      check(g, 2 * TBL[i][3:0]);
      check(nbytes, TBL[i][7:4]);
      check(a, 1);
    end
  endtask

  task automatic t_xdata;
    int g, a;
    run_op(8'hF0, 16'h3456, 3'h0, g, a);
    got = 8'h00;
    run_op(8'hE0, 16'h3456, 3'h0, g, a);
    check(got, 8'hF3);
    slow = 1'b1;
    got = 8'h00;
    run_op(8'hE0, 16'h3456, 3'h2, g, a);
    check(g, 12);
    check(got, 8'hF3);
    run_op(8'hF2, 16'h0077, 3'h7, g, a);
    check(g, 22);
    slow = 1'b0;
    got = 8'h00;
    run_op(8'hE2, 16'h0077, 3'h0, g, a);
    check(got, 8'hD2);
  endtask

  task automatic t_baud;
    int n = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      baud_in <= (k % 4 == 0);
      @(negedge sys_clk);
      n += baud_out;
    end
    check(n, 2);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_timer;
    t_table;
    t_xdata;
    t_baud;
    tally_and_finish;
  end

  initial begin
    #60000;
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
